// ---- verilog/bmc_boot_ctrl.sv ----
// Purpose: boot sequencing: reset hold, mode sampling, cpu stall release
// Assumes: host ports and register port synchronous to I_SYS_CLK
// Notes: host reads answer three cycles after the strobe
// Operation
// - hold everything in reset while reset low
// - start with sampled configuration after release
// - three modes: host, memory copy, none
// - host boot stalls cpu, releases the rest
// - host reaches all memory while stalled
// - host port select picks parallel or pci
// - that bit releases stall, fetch from zero
// - boot-ending host interrupt not pending at cpu
// - bit releases stall only in host mode
// - no new host interrupt until cpu clears
// - memory boot copies rom block to zero
// - pack four rom bytes into one word
// - copy is one single-frame block transfer
// - copy completion releases the cpu stall
// - no boot runs directly from address zero
// - no boot waits for sdram initialization
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "bmc_consts.svh"
module bmc_boot_ctrl #(
  parameter int ROM_BYTES = `BMC_ROM_BYTES,
  parameter logic [31:0] ROM_BASE = `BMC_ROM_BASE,
  parameter logic [31:0] HCTL_ADDR = `BMC_HCTL_ADDR
) (
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  input wire logic [1:0] I_BOOT_MODE,
  input wire logic I_HOST_PORT_SEL,
  input wire logic I_BIG_ENDIAN,
  input wire logic I_SDRAM_USED,
  input wire logic I_SDRAM_INIT_DONE,
  input wire logic I_HP_WR,
  input wire logic I_HP_RD,
  input wire logic [31:0] I_HP_ADDR,
  input wire logic [31:0] I_HP_WDATA,
  input wire logic I_PCI_WR,
  input wire logic I_PCI_RD,
  input wire logic [31:0] I_PCI_ADDR,
  input wire logic [31:0] I_PCI_WDATA,
  output logic [31:0] O_HOST_RDATA,
  output logic O_MEM_WR,
  output logic O_MEM_RD,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  input wire logic [31:0] I_MEM_RDATA,
  output logic O_ROM_RD,
  output logic [31:0] O_ROM_ADDR,
  input wire logic [7:0] I_ROM_DATA,
  input wire logic I_ROM_VALID,
  output logic O_CPU_STALL,
  output logic O_CPU_START,
  output logic [31:0] O_CPU_PC,
  output logic O_CPU_HOST_INT,
  output logic O_PERIPH_RST_N,
  input wire logic [7:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  output logic O_IRQ
);
  bmc_pkg::bmc_state_t state_ff;
  bmc_pkg::bmc_state_t nxt_state;
  bmc_pkg::bmc_mode_t mode_ff;
  logic sel_ff;
  logic big_ff;
  logic sdram_ff;
  logic hint_ff;
  logic start_ff;
  logic hostint_ff;
  logic prst_n_ff;
  logic [31:0] pc_ff;
  logic mem_wr_ff;
  logic mem_rd_ff;
  logic [31:0] mem_addr_ff;
  logic [31:0] mem_wdata_ff;
  logic hrd1_ff;
  logic hrd2_ff;
  logic hctl1_ff;
  logic hctl2_ff;
  logic [31:0] host_rdata_ff;
  logic [31:0] reg_rdata_ff;
  logic [`BMC_EV_W-1:0] ev_stat_ff;
  logic [`BMC_EV_W-1:0] ev_en_ff;
  logic [`BMC_EV_W-1:0] ev_set;
  logic h_wr;
  logic h_rd;
  logic [31:0] h_addr;
  logic [31:0] h_wdata;
  logic h_en;
  logic h_ctl;
  logic h_set;
  logic hint_clr;
  logic in_run;
  logic copying;
  logic cp_done;
  logic cp_mem_wr;
  logic [31:0] cp_mem_addr;
  logic [31:0] cp_mem_wdata;

  // strap code to boot mode; reserved code falls back to no boot
  function automatic bmc_pkg::bmc_mode_t bmc_decode_mode(input logic [1:0] code);
    case (code)
      2'h1: bmc_decode_mode = bmc_pkg::MODE_HOST;
      2'h2: bmc_decode_mode = bmc_pkg::MODE_EMEM;
      default: bmc_decode_mode = bmc_pkg::MODE_NONE;
    endcase
  endfunction

  // host port selection from the sampled select strap
  assign h_wr = sel_ff ? I_PCI_WR : I_HP_WR;
  assign h_rd = sel_ff ? I_PCI_RD : I_HP_RD;
  assign h_addr = sel_ff ? I_PCI_ADDR : I_HP_ADDR;
  assign h_wdata = sel_ff ? I_PCI_WDATA : I_HP_WDATA;

  // host traffic counts only in host mode once the straps are taken
  assign h_en = (mode_ff == bmc_pkg::MODE_HOST) && (state_ff != bmc_pkg::ST_SAMPLE);
  assign h_ctl = (h_addr == HCTL_ADDR);
  assign h_set = h_en && h_wr && h_ctl && h_wdata[`BMC_HCTL_HINT];
  assign hint_clr = I_REG_WR && (I_REG_ADDR == `BMC_A_CTRL)
    && I_REG_WDATA[`BMC_CTRL_HINT_CLR];
  assign in_run = (state_ff == bmc_pkg::ST_RUN);
  assign copying = (state_ff == bmc_pkg::ST_COPY);

  // next boot state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bmc_pkg::ST_SAMPLE: begin
        case (bmc_decode_mode(I_BOOT_MODE))
          bmc_pkg::MODE_HOST: nxt_state = bmc_pkg::ST_HOST;
          bmc_pkg::MODE_EMEM: nxt_state = bmc_pkg::ST_COPY;
          default: nxt_state = bmc_pkg::ST_SDRAM;
        endcase
      end
      bmc_pkg::ST_HOST: begin
        if (h_set) begin
          nxt_state = bmc_pkg::ST_RUN;
        end
      end
      bmc_pkg::ST_COPY: begin
        if (cp_done) begin
          nxt_state = bmc_pkg::ST_RUN;
        end
      end
      bmc_pkg::ST_SDRAM: begin
        if (!sdram_ff || I_SDRAM_INIT_DONE) begin
          nxt_state = bmc_pkg::ST_RUN;
        end
      end
      bmc_pkg::ST_RUN: nxt_state = bmc_pkg::ST_RUN;
      default: nxt_state = bmc_pkg::ST_SAMPLE;
    endcase
  end

  // boot state register
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_ff <= bmc_pkg::ST_SAMPLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // straps caught on the first edge after release, then frozen
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mode_ff <= bmc_pkg::MODE_NONE;
      sel_ff <= 1'b0;
      big_ff <= 1'b0;
      sdram_ff <= 1'b0;
    end else if (state_ff == bmc_pkg::ST_SAMPLE) begin
      mode_ff <= bmc_decode_mode(I_BOOT_MODE);
      sel_ff <= I_HOST_PORT_SEL;
      big_ff <= I_BIG_ENDIAN;
      sdram_ff <= I_SDRAM_USED;
    end
  end

  // cpu release: one start pulse, fetch address zero
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      start_ff <= 1'b0;
      pc_ff <= 32'h0;
      prst_n_ff <= 1'b0;
    end else begin
      start_ff <= (nxt_state == bmc_pkg::ST_RUN) && !in_run;
      pc_ff <= `BMC_BOOT_ADDR;
      prst_n_ff <= 1'b1;
    end
  end

  // host interrupt bit: set wins over the cpu clear, except a set refused after boot while the bit is already set
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hint_ff <= 1'b0;
    end else if (h_set && !(in_run && hint_ff)) begin
      hint_ff <= 1'b1;
    end else if (hint_clr) begin
      hint_ff <= 1'b0;
    end
  end

  // cpu interrupt only after boot and only while the bit is clear
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hostint_ff <= 1'b0;
    end else begin
      hostint_ff <= h_set && in_run && !hint_ff;
    end
  end

  // memory port: copy engine while copying, host forwarding otherwise
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      mem_wr_ff <= 1'b0;
      mem_rd_ff <= 1'b0;
      mem_addr_ff <= 32'h0;
      mem_wdata_ff <= 32'h0;
    end else if (copying) begin
      mem_wr_ff <= cp_mem_wr;
      mem_rd_ff <= 1'b0;
      mem_addr_ff <= cp_mem_addr;
      mem_wdata_ff <= cp_mem_wdata;
    end else begin
      mem_wr_ff <= h_en && h_wr && !h_ctl;
      mem_rd_ff <= h_en && h_rd && !h_ctl;
      mem_addr_ff <= h_addr;
      mem_wdata_ff <= h_wdata;
    end
  end

  // host read pipeline: strobe, memory read, data capture
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hrd1_ff <= 1'b0;
      hrd2_ff <= 1'b0;
      hctl1_ff <= 1'b0;
      hctl2_ff <= 1'b0;
      host_rdata_ff <= 32'h0;
    end else begin
      hrd1_ff <= h_en && h_rd && !copying;
      hctl1_ff <= h_ctl;
      hrd2_ff <= hrd1_ff;
      hctl2_ff <= hctl1_ff;
      if (hrd2_ff && hctl2_ff) begin
        host_rdata_ff <= 32'(hint_ff) << `BMC_HCTL_HINT;
      end else if (hrd2_ff) begin
        host_rdata_ff <= I_MEM_RDATA;
      end
    end
  end

  // boot copy engine
  bmc_copy_eng #(
    .ROM_BYTES(ROM_BYTES),
    .ROM_BASE(ROM_BASE)
  ) u_copy (
    .i_clk(I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .i_go(copying),
    .i_big_endian(big_ff),
    .o_rom_rd(O_ROM_RD),
    .o_rom_addr(O_ROM_ADDR),
    .i_rom_data(I_ROM_DATA),
    .i_rom_valid(I_ROM_VALID),
    .o_mem_wr(cp_mem_wr),
    .o_mem_addr(cp_mem_addr),
    .o_mem_wdata(cp_mem_wdata),
    .o_done(cp_done)
  );

  // events: boot done, host interrupt taken, host interrupt refused
  assign ev_set[`BMC_EV_DONE] = start_ff;
  assign ev_set[`BMC_EV_HINT] = hostint_ff;
  assign ev_set[`BMC_EV_HREJ] = h_set && in_run && hint_ff;

  // sticky event bits, set wins over write-one clear
  for (genvar i = 0; i < `BMC_EV_W; i++) begin : g_ev
    always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
        ev_stat_ff[i] <= 1'b0;
      end else if (ev_set[i]) begin
        ev_stat_ff[i] <= 1'b1;
      end else if (I_REG_WR && I_REG_ADDR == `BMC_A_EV_CLR && I_REG_WDATA[i]) begin
        ev_stat_ff[i] <= 1'b0;
      end
    end
  end

  // event enable register
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ev_en_ff <= '0;
    end else if (I_REG_WR && I_REG_ADDR == `BMC_A_EV_EN) begin
      ev_en_ff <= I_REG_WDATA[`BMC_EV_W-1:0];
    end
  end

  // register read data, one cycle after the read strobe
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      reg_rdata_ff <= 32'h0;
    end else if (I_REG_RD) begin
      case (I_REG_ADDR)
        `BMC_A_STATUS: reg_rdata_ff <= {22'h0, sdram_ff, big_ff, hint_ff,
          O_CPU_STALL, sel_ff, mode_ff, state_ff};
        `BMC_A_EV_STAT: reg_rdata_ff <= 32'(ev_stat_ff);
        `BMC_A_EV_EN: reg_rdata_ff <= 32'(ev_en_ff);
        default: reg_rdata_ff <= 32'h0;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0;
    end
  end

  // outputs
  assign O_CPU_STALL = !in_run;
  assign O_CPU_START = start_ff;
  assign O_CPU_PC = pc_ff;
  assign O_CPU_HOST_INT = hostint_ff;
  assign O_PERIPH_RST_N = prst_n_ff;
  assign O_MEM_WR = mem_wr_ff;
  assign O_MEM_RD = mem_rd_ff;
  assign O_MEM_ADDR = mem_addr_ff;
  assign O_MEM_WDATA = mem_wdata_ff;
  assign O_HOST_RDATA = host_rdata_ff;
  assign O_REG_RDATA = reg_rdata_ff;
  assign O_IRQ = |(ev_stat_ff & ev_en_ff);

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  chk_release_stalled: assert property (
    state_ff == bmc_pkg::ST_SAMPLE |-> O_CPU_STALL && !O_CPU_START && !O_MEM_WR)
    else $error("cpu not held on first cycle after reset");
  chk_host_release: assert property (
    state_ff == bmc_pkg::ST_HOST && h_set |=> O_CPU_START && !O_CPU_STALL
      && O_CPU_PC == `BMC_BOOT_ADDR ##1 !O_CPU_START)
    else $error("host bit did not release the cpu");
  chk_boot_int_dropped: assert property (
    state_ff == bmc_pkg::ST_HOST && h_set |=> !O_CPU_HOST_INT)
    else $error("boot-ending host interrupt reached cpu");
  chk_no_host_release: assert property (
    mode_ff != bmc_pkg::MODE_HOST && copying && !cp_done && h_wr && h_ctl
      |=> O_CPU_STALL && !O_CPU_START)
    else $error("host bit released cpu outside host mode");
  chk_hint_blocked: assert property (
    in_run && hint_ff && h_set |=> !O_CPU_HOST_INT && ev_stat_ff[`BMC_EV_HREJ])
    else $error("host interrupt taken while bit still set");
  chk_hint_taken: assert property (
    in_run && !hint_ff && h_set |=> O_CPU_HOST_INT && hint_ff ##1 !O_CPU_HOST_INT)
    else $error("host interrupt not taken");
  chk_straps_held: assert property (
    state_ff != bmc_pkg::ST_SAMPLE |=> $stable(mode_ff) && $stable(sel_ff))
    else $error("straps changed after sampling");
  chk_sdram_wait: assert property (
    state_ff == bmc_pkg::ST_SDRAM && sdram_ff && !I_SDRAM_INIT_DONE |=> O_CPU_STALL)
    else $error("cpu left stall before sdram ready");
  chk_copy_release: assert property (cp_done |=> O_CPU_START ##1 !O_CPU_STALL)
    else $error("copy completion did not release cpu");
  chk_pci_route: assert property (
    h_en && sel_ff && I_PCI_WR && I_PCI_ADDR != HCTL_ADDR
      |=> O_MEM_WR && O_MEM_ADDR == $past(I_PCI_ADDR))
    else $error("pci write not routed to memory");
endmodule

// ---- verilog/bmc_consts.svh ----
// Purpose: shared constants of the boot mode controller
// Assumes: included by bare name from the design files
// Notes: byte addresses on the register port, host-space addresses
`ifndef BMC_CONSTS_SVH
`define BMC_CONSTS_SVH

// register port byte offsets
`define BMC_A_CTRL 8'h00
`define BMC_A_STATUS 8'h04
`define BMC_A_EV_STAT 8'h08
`define BMC_A_EV_CLR 8'h0c
`define BMC_A_EV_EN 8'h10

// control register: write one clears the host interrupt bit
`define BMC_CTRL_HINT_CLR 0

// host port control register, seen in the host address space
`define BMC_HCTL_ADDR 32'h01f0_0000
`define BMC_HCTL_HINT 0

// event bits of the sticky status register
`define BMC_EV_DONE 0
`define BMC_EV_HINT 1
`define BMC_EV_HREJ 2
`define BMC_EV_W 3

// boot copy geometry
`define BMC_BOOT_ADDR 32'h0000_0000
`define BMC_ROM_BASE 32'h6400_0000
`define BMC_ROM_BYTES 1024

`endif

// ---- verilog/bmc_pkg.sv ----
// Purpose: types of the boot mode controller
// Assumes: nothing is imported; users write bmc_pkg::name
// Notes: binary codes written out
package bmc_pkg;

  // sampled boot mode; code 2'h3 is reserved and decoded as no boot
  typedef enum logic [1:0] {
    MODE_NONE = 2'h0,
    MODE_HOST = 2'h1,
    MODE_EMEM = 2'h2
  } bmc_mode_t;

  // top-level boot sequence
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_HOST = 3'h1,
    ST_COPY = 3'h2,
    ST_SDRAM = 3'h3,
    ST_RUN = 3'h4
  } bmc_state_t;

  // rom-to-memory copy engine
  typedef enum logic [2:0] {
    CP_IDLE = 3'h0,
    CP_REQ = 3'h1,
    CP_WAIT = 3'h2,
    CP_WR = 3'h3,
    CP_DONE = 3'h4
  } bmc_cp_state_t;

endpackage

// ---- verilog/bmc_copy_eng.sv ----
// Purpose: single-frame block copy of the boot rom to address zero
// Assumes: rom answers each read with one i_rom_valid pulse
// Notes: bytes packed four to a word in the selected byte order
`timescale 1ns/1ps
`include "bmc_consts.svh"
module bmc_copy_eng #(
  parameter int ROM_BYTES = `BMC_ROM_BYTES,
  parameter logic [31:0] ROM_BASE = `BMC_ROM_BASE
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_go,
  input wire logic i_big_endian,
  output logic o_rom_rd,
  output logic [31:0] o_rom_addr,
  input wire logic [7:0] i_rom_data,
  input wire logic i_rom_valid,
  output logic o_mem_wr,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  output logic o_done
);
  localparam int BW = $clog2(ROM_BYTES);

  bmc_pkg::bmc_cp_state_t state_ff;
  logic [BW-1:0] cnt_ff;
  logic [31:0] word_ff;
  logic [1:0] lane;
  logic last;

  // byte lane of the current byte, per system byte order
  assign lane = i_big_endian ? 2'h3 - cnt_ff[1:0] : cnt_ff[1:0];
  assign last = (cnt_ff == BW'(ROM_BYTES - 1));

  // request, write and completion strobes
  assign o_rom_rd = (state_ff == bmc_pkg::CP_REQ);
  assign o_rom_addr = ROM_BASE + 32'(cnt_ff);
  assign o_mem_wr = (state_ff == bmc_pkg::CP_WR);
  assign o_mem_addr = `BMC_BOOT_ADDR + 32'({cnt_ff[BW-1:2], 2'b00});
  assign o_mem_wdata = word_ff;
  assign o_done = o_mem_wr && last;

  // byte walk: read, collect four bytes, write one word
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= bmc_pkg::CP_IDLE;
      cnt_ff <= '0;
    end else begin
      case (state_ff)
        bmc_pkg::CP_IDLE: begin
          cnt_ff <= '0;
          if (i_go) begin
            state_ff <= bmc_pkg::CP_REQ;
          end
        end
        bmc_pkg::CP_REQ: state_ff <= bmc_pkg::CP_WAIT;
        bmc_pkg::CP_WAIT: begin
          if (i_rom_valid && cnt_ff[1:0] == 2'h3) begin
            state_ff <= bmc_pkg::CP_WR;
          end else if (i_rom_valid) begin
            cnt_ff <= cnt_ff + BW'(1);
            state_ff <= bmc_pkg::CP_REQ;
          end
        end
        bmc_pkg::CP_WR: begin
          if (last) begin
            state_ff <= bmc_pkg::CP_DONE;
          end else begin
            cnt_ff <= cnt_ff + BW'(1);
            state_ff <= bmc_pkg::CP_REQ;
          end
        end
        bmc_pkg::CP_DONE: begin
          if (!i_go) begin
            state_ff <= bmc_pkg::CP_IDLE;
          end
        end
        default: state_ff <= bmc_pkg::CP_IDLE;
      endcase
    end
  end

  // byte packer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_ff <= 32'h0;
    end else if (state_ff == bmc_pkg::CP_WAIT && i_rom_valid) begin
      word_ff[{lane, 3'b000} +: 8] <= i_rom_data;
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_pack_word: assert property (o_mem_wr |-> cnt_ff[1:0] == 2'h3)
    else $error("word written before four bytes packed");
  chk_copy_length: assert property (
    o_done |-> o_mem_addr == `BMC_BOOT_ADDR + 32'(ROM_BYTES - 4))
    else $error("copy ended at wrong length");
  chk_one_read: assert property (o_rom_rd |=> !o_rom_rd [*1] ##0 !o_mem_wr)
    else $error("rom read not single outstanding");
endmodule

// ---- sim/bmc_far_model.sv ----
// Purpose: far-side model: boot rom on the external bus and memory at address zero
// Assumes: one rom byte outstanding at a time; memory read data the cycle after the strobe
// Notes: between answers the data lines toggle, so stale values never pass for valid
`timescale 1ns/1ps
module bmc_far_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [3:0] i_rom_delay,
  input wire logic i_rom_rd,
  input wire logic [31:0] i_rom_addr,
  output logic [7:0] o_rom_data,
  output logic o_rom_valid,
  input wire logic i_mem_wr,
  input wire logic i_mem_rd,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_mem_wdata,
  output logic [31:0] o_mem_rdata
);
  logic [31:0] mem [0:63];
  logic pend_ff;
  logic [3:0] cnt_ff;
  logic [7:0] idx_ff;
  int wr_cnt;

  // memory starts cleared so untouched words read as zero
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0000_0000;
    end
  end

  // rom answers one byte after a programmable wait; image kept in byte order
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
      idx_ff <= 8'h00;
      o_rom_valid <= 1'b0;
      o_rom_data <= 8'h00;
    end else begin
      o_rom_valid <= 1'b0;
      o_rom_data <= ~o_rom_data;
      if (i_rom_rd) begin
        pend_ff <= 1'b1;
        cnt_ff <= i_rom_delay;
        idx_ff <= i_rom_addr[7:0];
      end else if (pend_ff && cnt_ff == 4'h0) begin
        pend_ff <= 1'b0;
        o_rom_valid <= 1'b1;
        o_rom_data <= 8'h3c ^ idx_ff;
      end else if (pend_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end

  // word memory with write counter; read data toggles when not answering
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_cnt <= 0;
      o_mem_rdata <= 32'h0000_0000;
    end else begin
      o_mem_rdata <= i_mem_rd ? mem[i_mem_addr[7:2]] : ~o_mem_rdata;
      if (i_mem_wr) begin
        mem[i_mem_addr[7:2]] <= i_mem_wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end
  end
endmodule

// ---- sim/testbench.sv ----
// Purpose: self-checking bench of the boot mode controller
// Assumes: rom of 16 bytes so the copy stays short
// Notes: host and register accesses driven by nonblocking assignment after the edge
`timescale 1ns/1ps
`include "bmc_consts.svh"
module testbench;
  logic sys_clk, arst_n, port_sel, big_end, sdram_used, sdram_done;
  logic [1:0] boot_mode;
  logic hp_wr, hp_rd, pci_wr, pci_rd, reg_wr, reg_rd;
  logic [31:0] hp_addr, hp_wdata, pci_addr, pci_wdata, reg_wdata, rv;
  logic [7:0] reg_addr;
  logic [3:0] rom_delay;
  logic [31:0] host_rdata, mem_addr, mem_wdata, mem_rdata, rom_addr, cpu_pc, reg_rdata;
  logic mem_wr, mem_rd, rom_rd, rom_valid, cpu_stall, cpu_start, cpu_host_int;
  logic periph_rst_n, irq;
  logic [7:0] rom_data;
  int fails, cmp_count;

  bmc_boot_ctrl #(.ROM_BYTES(16)) DUT (.I_SYS_CLK(sys_clk), .I_ARST_N(arst_n),
    .I_BOOT_MODE(boot_mode), .I_HOST_PORT_SEL(port_sel), .I_BIG_ENDIAN(big_end),
    .I_SDRAM_USED(sdram_used), .I_SDRAM_INIT_DONE(sdram_done), .I_HP_WR(hp_wr),
    .I_HP_RD(hp_rd), .I_HP_ADDR(hp_addr), .I_HP_WDATA(hp_wdata), .I_PCI_WR(pci_wr),
    .I_PCI_RD(pci_rd), .I_PCI_ADDR(pci_addr), .I_PCI_WDATA(pci_wdata),
    .O_HOST_RDATA(host_rdata), .O_MEM_WR(mem_wr), .O_MEM_RD(mem_rd), .O_MEM_ADDR(mem_addr),
    .O_MEM_WDATA(mem_wdata), .I_MEM_RDATA(mem_rdata), .O_ROM_RD(rom_rd),
    .O_ROM_ADDR(rom_addr), .I_ROM_DATA(rom_data), .I_ROM_VALID(rom_valid),
    .O_CPU_STALL(cpu_stall), .O_CPU_START(cpu_start), .O_CPU_PC(cpu_pc),
    .O_CPU_HOST_INT(cpu_host_int), .O_PERIPH_RST_N(periph_rst_n), .I_REG_ADDR(reg_addr),
    .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata),
    .O_IRQ(irq));

  bmc_far_model u_far (.i_clk(sys_clk), .i_arst_n(arst_n), .i_rom_delay(rom_delay),
    .i_rom_rd(rom_rd), .i_rom_addr(rom_addr), .o_rom_data(rom_data), .o_rom_valid(rom_valid),
    .i_mem_wr(mem_wr), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
    .o_mem_rdata(mem_rdata));

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // compare and count
  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // host access on the parallel port or pci; read data sampled three cycles on
  task automatic host_access(input logic pci, input logic wr, input logic [31:0] a,
                             input logic [31:0] d);
    @(posedge sys_clk);
    if (pci) begin
      pci_wr <= wr;
      pci_rd <= !wr;
      pci_addr <= a;
      pci_wdata <= d;
    end else begin
      hp_wr <= wr;
      hp_rd <= !wr;
      hp_addr <= a;
      hp_wdata <= d;
    end
    @(posedge sys_clk);
    {hp_wr, hp_rd, pci_wr, pci_rd} <= 4'h0;
    if (!wr) begin
      repeat (2) @(posedge sys_clk);
      #1 rv = host_rdata;
    end
  endtask

  // reset with straps set; released after 13 cycles
  task automatic do_reset(input logic [1:0] m, input logic s, input logic b, input logic d,
                          input logic [3:0] dl);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    boot_mode <= m;
    port_sel <= s;
    big_end <= b;
    sdram_used <= d;
    sdram_done <= 1'b0;
    rom_delay <= dl;
    repeat (12) @(posedge sys_clk);
    #1 chk({cpu_stall, periph_rst_n, cpu_start, irq}, 4'h8);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic wait_start(input int lim);
    int n;
    n = 0;
    while (cpu_start !== 1'b1 && n < lim) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= lim) begin
      fails++;
      $display("[ERR] %0t cpu start never seen", $time);
      summarize();
    end
  endtask

  // memory boot: host ignored, rom bytes packed and copied, then cpu released
  task automatic mem_boot(input logic b, input logic [3:0] dl);
    logic [7:0] by [0:3];
    do_reset(2'h2, 1'b0, b, 1'b0, dl);
    host_access(1'b0, 1'b1, `BMC_HCTL_ADDR, 32'h1);
    #1 chk(cpu_stall, 1'b1);
    wait_start(2000);
    chk({cpu_stall, cpu_pc}, 33'h0);
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++) begin
        by[j] = 8'h3c ^ 8'(4 * k + j);
      end
      chk(u_far.mem[k], b ? {by[0], by[1], by[2], by[3]} : {by[3], by[2], by[1], by[0]});
    end
    chk(32'(u_far.wr_cnt), 32'd4);
  endtask

  // stimulus: memory boot both byte orders, host boot both ports, no boot
  initial begin
    {arst_n, boot_mode, port_sel, big_end, sdram_used, sdram_done} = 7'h0;
    {hp_wr, hp_rd, pci_wr, pci_rd, reg_wr, reg_rd} = 6'h0;
    {hp_addr, hp_wdata, pci_addr, pci_wdata, reg_wdata} = 160'h0;
    reg_addr = 8'h00;
    rom_delay = 4'h0;
    fails = 0;
    cmp_count = 0;
    mem_boot(1'b0, 4'h0);
    mem_boot(1'b1, 4'h5);
    for (int p = 0; p < 2; p++) begin
      do_reset(2'h1, p[0], 1'b0, 1'b0, 4'h0);
      #1 chk({cpu_stall, periph_rst_n}, 2'h3);
      reg_access(1'b1 ^ 1'b1, `BMC_A_STATUS, 32'h0);
      chk(rv & 32'h3f, {26'h0, p[0], 5'h09});
      host_access(!p[0], 1'b1, 32'h24, 32'hdead_0001);
      host_access(p[0], 1'b1, 32'h20, 32'h1234_5678);
      host_access(p[0], 1'b0, 32'h20, 32'h0);
      chk(rv, 32'h1234_5678);
      chk(u_far.mem[9], 32'h0);
      host_access(p[0], 1'b1, `BMC_HCTL_ADDR, 32'h1);
      #1 chk({cpu_start, cpu_stall, cpu_host_int, cpu_pc}, {3'h4, 32'h0});
      @(posedge sys_clk);
      #1 chk(cpu_host_int, 1'b0);
      host_access(p[0], 1'b0, `BMC_HCTL_ADDR, 32'h0);
      chk(rv, 32'h1);
      host_access(p[0], 1'b1, `BMC_HCTL_ADDR, 32'h1);
      #1 chk(cpu_host_int, 1'b0);
      reg_access(1'b0, `BMC_A_EV_STAT, 32'h0);
      chk(rv, 32'h5);
      chk(irq, 1'b0);
      reg_access(1'b1, `BMC_A_EV_EN, 32'h4);
      #1 chk(irq, 1'b1);
      reg_access(1'b0, `BMC_A_EV_EN, 32'h0);
      chk(rv, 32'h4);
      reg_access(1'b1, `BMC_A_EV_CLR, 32'h4);
      #1 chk(irq, 1'b0);
      reg_access(1'b1, `BMC_A_CTRL, 32'h1);
      host_access(p[0], 1'b1, `BMC_HCTL_ADDR, 32'h1);
      #1 chk(cpu_host_int, 1'b1);
      reg_access(1'b0, 8'h3c, 32'h0);
      chk(rv, 32'h0);
    end
    do_reset(2'h0, 1'b0, 1'b0, 1'b1, 4'h0);
    repeat (50) @(posedge sys_clk);
    #1 chk({cpu_stall, cpu_start}, 2'h2);
    @(posedge sys_clk);
    boot_mode <= 2'h1;
    reg_access(1'b0, `BMC_A_STATUS, 32'h0);
    chk(rv & 32'h18, 32'h0);
    @(posedge sys_clk);
    sdram_done <= 1'b1;
    wait_start(10);
    chk({cpu_stall, cpu_pc, 32'(u_far.wr_cnt)}, 65'h0);
    do_reset(2'h3, 1'b0, 1'b0, 1'b0, 4'h0);
    wait_start(10);
    chk({cpu_stall, 32'(u_far.wr_cnt)}, 33'h0);
    summarize();
  end
endmodule
